// >>> logic/berr_pkg.sv
package berr_pkg;
   // ==========================================
   // Error codes
   localparam logic [3:0] CODE_NONE          = 4'h0;
   localparam logic [3:0] CODE_NOT_IN_CHARGE = 4'h1;
   localparam logic [3:0] CODE_NO_LISTENER   = 4'h2;
   localparam logic [3:0] CODE_NOT_ADDRESSED = 4'h3;
   localparam logic [3:0] CODE_BAD_ARGUMENT  = 4'h4;
   // ==========================================
   // Call argument limits
   localparam logic [15:0] WRITE_COUNT_MAX   = 16'h0100;
   // ==========================================
   // Status word error flag position (weight -32768)
   localparam int          ERR_FLAG_BIT      = 15;
   // ==========================================
   // Host modes
   typedef enum logic { BERR_MODE_SCSI, BERR_MODE_GPIB } berr_mode_t;
   // Call kinds
   typedef enum logic [3:0]
   {
      BERR_CALL_OTHER,
      BERR_CALL_CTRL_FN,
      BERR_CALL_WRITE,
      BERR_CALL_BWRITE,
      BERR_CALL_BREAD,
      BERR_CALL_READ,
      BERR_CALL_DTIN,
      BERR_CALL_GTS,
      BERR_CALL_CMD,
      BERR_CALL_TID
   } berr_call_t;
   // Sequencer states
   typedef enum logic [1:0] { BERR_ST_IDLE, BERR_ST_XFER, BERR_ST_DONE } berr_state_t;
endpackage : berr_pkg

// >>> logic/berr_reporter.sv
// Function
// - One bus error code, replaced per call
// - Error flag set implies a reported cause
// - Code zero when no bus error
// - SCSI mode, not in charge, control function call: code 1
// - In charge, write with no listener: code 2
// - ATN while not in charge during a watched transfer (GPIB read/DTIN, SCSI write/bwrite): code 2
// - SCSI mode, in charge, byte call unaddressed: code 3
// - Standby shadow request, ATN off: code 3
// - Command bytes leave ATN asserted
// - GPIB mode invalid argument: code 4
// - Write count over 256: code 4
// - Read with one parameter: code 4
// - Target-id without parameter or query: code 4
// - Invalid argument: function not executed
// - Corrupt terminator or field: code 4
// - Error flag set on fail, cleared on success
// - Flag with code zero: SCSI side fault
`timescale 1ns/1ns
`default_nettype none
module berr_reporter
(
   input  wire logic                  core_clk,
   input  wire logic                  reset,
   input  wire logic                  call_valid,
   input  wire berr_pkg::berr_call_t  call_kind,
   input  wire berr_pkg::berr_mode_t  host_mode,
   input  wire logic [15:0]           call_count,
   input  wire logic [2:0]            call_param_count,
   input  wire logic                  call_query,
   input  wire logic                  call_shadow,
   input  wire logic                  call_arg_bad,
   input  wire logic                  call_term_bad,
   input  wire logic                  controller_in_charge,
   input  wire logic                  listener_present,
   input  wire logic                  self_addressed,
   input  wire logic                  atn_in,
   input  wire logic                  xfer_done,
   input  wire logic                  scsi_error,
   output logic                       call_busy,
   output logic                       call_done,
   output logic                       bus_start,
   output logic                       atn_out,
   output logic [3:0]                 bus_error_code,
   output logic                       error_flag,
   output logic                       scsi_side_fault
);
   berr_pkg::berr_state_t state;
   berr_pkg::berr_call_t  cur_kind;
   logic [3:0]            next_code;
   logic                  pending_scsi;
   logic                  cur_xfer;
   logic                  take;
   logic                  atn_abort;

   // ==========================================
   // Call checks, evaluated before any bus action
   always_comb
   begin
      next_code = berr_pkg::CODE_NONE;
      if (call_term_bad || call_arg_bad)
         next_code = berr_pkg::CODE_BAD_ARGUMENT;
      else if (call_kind == berr_pkg::BERR_CALL_WRITE && call_count > berr_pkg::WRITE_COUNT_MAX)
         next_code = berr_pkg::CODE_BAD_ARGUMENT;
      else if (call_kind == berr_pkg::BERR_CALL_READ && call_param_count == 3'h1)
         next_code = berr_pkg::CODE_BAD_ARGUMENT;
      else if (call_kind == berr_pkg::BERR_CALL_TID && call_param_count == 3'h0 && !call_query)
         next_code = berr_pkg::CODE_BAD_ARGUMENT;
      else if (host_mode == berr_pkg::BERR_MODE_SCSI && !controller_in_charge
               && call_kind == berr_pkg::BERR_CALL_CTRL_FN)
         next_code = berr_pkg::CODE_NOT_IN_CHARGE;
      else if (host_mode == berr_pkg::BERR_MODE_SCSI && controller_in_charge && !self_addressed
               && (call_kind == berr_pkg::BERR_CALL_BREAD
                   || call_kind == berr_pkg::BERR_CALL_BWRITE))
         next_code = berr_pkg::CODE_NOT_ADDRESSED;
      else if (call_kind == berr_pkg::BERR_CALL_GTS && call_shadow && !atn_out)
         next_code = berr_pkg::CODE_NOT_ADDRESSED;
      else if ((call_kind == berr_pkg::BERR_CALL_WRITE || call_kind == berr_pkg::BERR_CALL_BWRITE)
               && controller_in_charge && !listener_present)
         next_code = berr_pkg::CODE_NO_LISTENER;
   end

   // Transfers watched for ATN from another controller
   always_comb
   begin
      cur_xfer = 1'b0;
      if (host_mode == berr_pkg::BERR_MODE_GPIB)
         cur_xfer = (cur_kind == berr_pkg::BERR_CALL_READ || cur_kind == berr_pkg::BERR_CALL_DTIN);
      else
         cur_xfer = (cur_kind == berr_pkg::BERR_CALL_WRITE
                     || cur_kind == berr_pkg::BERR_CALL_BWRITE);
   end

   // Helpers for the checks below
   assign take      = (state == berr_pkg::BERR_ST_IDLE) && call_valid;
   assign atn_abort = (state == berr_pkg::BERR_ST_XFER) && cur_xfer && !controller_in_charge
                      && atn_in;

   // ==========================================
   // Call sequencer
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state          <= berr_pkg::BERR_ST_IDLE;
         cur_kind       <= berr_pkg::BERR_CALL_OTHER;
         call_busy      <= 1'b0;
         call_done      <= 1'b0;
         bus_start      <= 1'b0;
         bus_error_code <= berr_pkg::CODE_NONE;
         error_flag     <= 1'b0;
         pending_scsi   <= 1'b0;
      end
      else
      begin
         call_done <= 1'b0;
         bus_start <= 1'b0;
         case (state)
            berr_pkg::BERR_ST_IDLE:
            begin
               if (call_valid)
               begin
                  cur_kind       <= call_kind;
                  call_busy      <= 1'b1;
                  bus_error_code <= next_code;
                  pending_scsi   <= scsi_error;
                  // Failed checks never touch the bus, so bad arguments are discarded whole
                  if (next_code == berr_pkg::CODE_NONE)
                  begin
                     bus_start <= 1'b1;
                     state     <= berr_pkg::BERR_ST_XFER;
                  end
                  else
                     state <= berr_pkg::BERR_ST_DONE;
               end
            end
            berr_pkg::BERR_ST_XFER:
            begin
               if (cur_xfer && !controller_in_charge && atn_in)
               begin
                  bus_error_code <= berr_pkg::CODE_NO_LISTENER;
                  state          <= berr_pkg::BERR_ST_DONE;
               end
               else if (xfer_done)
                  state <= berr_pkg::BERR_ST_DONE;
               if (scsi_error)
                  pending_scsi <= 1'b1;
            end
            berr_pkg::BERR_ST_DONE:
            begin
               call_busy  <= 1'b0;
               call_done  <= 1'b1;
               error_flag <= (bus_error_code != berr_pkg::CODE_NONE) || pending_scsi;
               state      <= berr_pkg::BERR_ST_IDLE;
            end
            default:
               state <= berr_pkg::BERR_ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // SCSI side fault indication
   always_ff @(posedge core_clk)
   begin
      if (reset)
         scsi_side_fault <= 1'b0;
      else if (state == berr_pkg::BERR_ST_DONE)
         scsi_side_fault <= pending_scsi && bus_error_code == berr_pkg::CODE_NONE;
   end

   // ==========================================
   // ATN ownership: command bytes leave it asserted for a later shadow handshake
   always_ff @(posedge core_clk)
   begin
      if (reset)
         atn_out <= 1'b0;
      else if (state == berr_pkg::BERR_ST_XFER && xfer_done)
      begin
         if (cur_kind == berr_pkg::BERR_CALL_CMD)
            atn_out <= 1'b1;
         else if (cur_kind == berr_pkg::BERR_CALL_GTS)
            atn_out <= 1'b0;
      end
   end

   // ==========================================
   // Checks
   AST_BADARG_WRITE: assert property (@(posedge core_clk) disable iff (reset)
      state == berr_pkg::BERR_ST_IDLE && call_valid && !call_arg_bad && !call_term_bad
      && call_kind == berr_pkg::BERR_CALL_WRITE && call_count > berr_pkg::WRITE_COUNT_MAX
      |=> bus_error_code == berr_pkg::CODE_BAD_ARGUMENT && !bus_start)
      else $error("Oversize write not flagged");
   AST_NO_EXEC: assert property (@(posedge core_clk) disable iff (reset)
      state == berr_pkg::BERR_ST_IDLE && call_valid && next_code != berr_pkg::CODE_NONE
      |=> !bus_start ##1 call_done && !bus_start)
      else $error("Failed call reached the bus");
   AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (reset)
      call_done |-> error_flag == ((bus_error_code != 4'h0) || $past(pending_scsi)))
      else $error("Error flag mismatches outcome");
   AST_FLAG_CAUSE: assert property (@(posedge core_clk) disable iff (reset)
      call_done && error_flag |-> bus_error_code != 4'h0 || scsi_side_fault)
      else $error("Error flag without cause");
   AST_NOT_IN_CHARGE: assert property (@(posedge core_clk) disable iff (reset)
      state == berr_pkg::BERR_ST_IDLE && call_valid && !call_arg_bad && !call_term_bad
      && host_mode == berr_pkg::BERR_MODE_SCSI && !controller_in_charge
      && call_kind == berr_pkg::BERR_CALL_CTRL_FN |=> bus_error_code == 4'h1)
      else $error("Not in charge code missing");
   AST_ATN_ABORT: assert property (@(posedge core_clk) disable iff (reset)
      state == berr_pkg::BERR_ST_XFER && cur_xfer && !controller_in_charge && atn_in
      |=> bus_error_code == 4'h2 ##1 call_done)
      else $error("ATN abort not reported");
   AST_CMD_ATN: assert property (@(posedge core_clk) disable iff (reset)
      state == berr_pkg::BERR_ST_XFER && xfer_done && cur_kind == berr_pkg::BERR_CALL_CMD
      |=> atn_out)
      else $error("Command left ATN released");
   AST_GTS_SHADOW: assert property (@(posedge core_clk) disable iff (reset)
      state == berr_pkg::BERR_ST_IDLE && call_valid && !call_arg_bad && !call_term_bad
      && call_kind == berr_pkg::BERR_CALL_GTS && call_shadow && !atn_out
      |=> bus_error_code == 4'h3 && !bus_start)
      else $error("Shadow handshake not refused");
   AST_OK_ZERO: assert property (@(posedge core_clk) disable iff (reset)
      state == berr_pkg::BERR_ST_IDLE && call_valid && next_code == 4'h0
      |=> bus_start && bus_error_code == 4'h0)
      else $error("Clean call left a code");

   // ==========================================
   // Code selection and call start checks
   AST_ONE_CODE: assert property (@(posedge core_clk) disable iff (reset)
      !take && !atn_abort |=> $stable(bus_error_code))
      else $error("Code changed outside a call");
   AST_CODE_RANGE: assert property (@(posedge core_clk) disable iff (reset)
      bus_error_code <= 4'h4)
      else $error("Code out of range");
   AST_NO_LISTENER: assert property (@(posedge core_clk) disable iff (reset)
      take && !call_arg_bad && !call_term_bad && call_kind == berr_pkg::BERR_CALL_WRITE
      && call_count <= berr_pkg::WRITE_COUNT_MAX && controller_in_charge && !listener_present
      |=> bus_error_code == 4'h2 && !bus_start)
      else $error("No listener not reported");
   AST_NOT_ADDRESSED: assert property (@(posedge core_clk) disable iff (reset)
      take && !call_arg_bad && !call_term_bad && host_mode == berr_pkg::BERR_MODE_SCSI
      && controller_in_charge && !self_addressed
      && (call_kind == berr_pkg::BERR_CALL_BREAD || call_kind == berr_pkg::BERR_CALL_BWRITE)
      |=> bus_error_code == 4'h3 && !bus_start)
      else $error("Unaddressed byte call not reported");
   AST_BADARG_FLAG: assert property (@(posedge core_clk) disable iff (reset)
      take && (call_arg_bad || call_term_bad)
      |=> bus_error_code == 4'h4 && !bus_start)
      else $error("Bad argument not reported");
   AST_BADARG_READ: assert property (@(posedge core_clk) disable iff (reset)
      take && !call_arg_bad && !call_term_bad && call_kind == berr_pkg::BERR_CALL_READ
      && call_param_count == 3'h1 |=> bus_error_code == 4'h4)
      else $error("Short read not reported");
   AST_BADARG_TID: assert property (@(posedge core_clk) disable iff (reset)
      take && !call_arg_bad && !call_term_bad && call_kind == berr_pkg::BERR_CALL_TID
      && call_param_count == 3'h0 && !call_query |=> bus_error_code == 4'h4)
      else $error("Empty target-id not reported");
   AST_SCSI_FAULT: assert property (@(posedge core_clk) disable iff (reset)
      call_done |-> scsi_side_fault == (error_flag && bus_error_code == 4'h0))
      else $error("SCSI side fault mismatch");
   AST_BUS_AFTER_CHECK: assert property (@(posedge core_clk) disable iff (reset)
      bus_start |-> bus_error_code == 4'h0 && state == berr_pkg::BERR_ST_XFER && call_busy)
      else $error("Bus started before checks passed");
   AST_BUSY_TAKE: assert property (@(posedge core_clk) disable iff (reset)
      take |=> call_busy)
      else $error("Accepted call not busy");

   // ==========================================
   // Sequencing checks
   AST_DONE_IDLE: assert property (@(posedge core_clk) disable iff (reset)
      call_done |-> !call_busy)
      else $error("Busy at call end");
   AST_DONE_PULSE: assert property (@(posedge core_clk) disable iff (reset)
      call_done |=> !call_done)
      else $error("Done pulse too long");
   AST_START_PULSE: assert property (@(posedge core_clk) disable iff (reset)
      bus_start |=> !bus_start)
      else $error("Start pulse too long");
   AST_XFER_BUSY: assert property (@(posedge core_clk) disable iff (reset)
      state == berr_pkg::BERR_ST_XFER |-> call_busy)
      else $error("Transfer while not busy");
   AST_IDLE_QUIET: assert property (@(posedge core_clk) disable iff (reset)
      state == berr_pkg::BERR_ST_IDLE && !call_valid |=> !call_busy && !bus_start)
      else $error("Activity without a call");
   AST_FINISH: assert property (@(posedge core_clk) disable iff (reset)
      state == berr_pkg::BERR_ST_XFER && xfer_done && !atn_abort
      |=> state == berr_pkg::BERR_ST_DONE ##1 call_done)
      else $error("Finished transfer did not end the call");
   AST_ATN_HOLD: assert property (@(posedge core_clk) disable iff (reset)
      !(state == berr_pkg::BERR_ST_XFER && xfer_done) |=> $stable(atn_out))
      else $error("ATN moved outside a completion");
   AST_GTS_RELEASE: assert property (@(posedge core_clk) disable iff (reset)
      state == berr_pkg::BERR_ST_XFER && xfer_done && cur_kind == berr_pkg::BERR_CALL_GTS
      |=> !atn_out)
      else $error("Standby left ATN asserted");
   AST_FLAG_HOLD: assert property (@(posedge core_clk) disable iff (reset)
      state != berr_pkg::BERR_ST_DONE |=> $stable(error_flag))
      else $error("Error flag moved mid-call");
endmodule : berr_reporter
`default_nettype wire

// >>> tb/berr_far_side.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Bus side: ends each started bus action after a set delay
module berr_far_side
(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       bus_start,
   input  wire logic       call_busy,
   input  wire logic [7:0] delay,
   output logic            xfer_done
);
   logic [7:0] left;
   // An aborted call must not see a stale completion later
   always_ff @(posedge core_clk)
   begin
      xfer_done <= 1'b0;
      if (reset || !call_busy)
         left <= 8'h00;
      else if (bus_start)
         left <= delay;
      else if (left == 8'h01)
      begin
         left      <= 8'h00;
         xfer_done <= 1'b1;
      end
      else if (left != 8'h00)
         left <= left - 8'h01;
   end
endmodule : berr_far_side
`default_nettype wire

// >>> tb/berr_reporter_tb.sv
`timescale 1ns/1ns
`default_nettype none
module berr_reporter_tb;
   // ==========================================
   // Stimulus and wiring
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic call_valid = 1'b0;
   berr_pkg::berr_call_t call_kind = berr_pkg::BERR_CALL_OTHER;
   berr_pkg::berr_mode_t host_mode = berr_pkg::BERR_MODE_SCSI;
   logic [15:0] call_count = 16'h0000;
   logic [2:0]  call_param_count = 3'h0;
   logic [3:0]  call_flags = 4'h0;
   logic        in_charge = 1'b1, listener = 1'b1, addr = 1'b1;
   logic        atn_in = 1'b0, scsi_error = 1'b0;
   logic        call_busy, call_done, bus_start, atn_out, error_flag, scsi_side_fault, xfer_done;
   logic [3:0]  bus_error_code;
   logic [7:0]  delay = 8'h03;
   int          err_total = 0, checks_done = 0, starts = 0;
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) if (bus_start === 1'b1) starts++;
   berr_reporter u_berr_reporter (.core_clk(core_clk), .reset(reset), .call_valid(call_valid),
      .call_kind(call_kind), .host_mode(host_mode), .call_count(call_count),
      .call_param_count(call_param_count), .call_query(call_flags[3]),
      .call_shadow(call_flags[2]), .call_arg_bad(call_flags[1]), .call_term_bad(call_flags[0]),
      .controller_in_charge(in_charge), .listener_present(listener), .self_addressed(addr),
      .atn_in(atn_in), .xfer_done(xfer_done), .scsi_error(scsi_error), .call_busy(call_busy),
      .call_done(call_done), .bus_start(bus_start), .atn_out(atn_out),
      .bus_error_code(bus_error_code), .error_flag(error_flag), .scsi_side_fault(scsi_side_fault));
   berr_far_side u_berr_far_side (.core_clk(core_clk), .reset(reset), .bus_start(bus_start),
      .call_busy(call_busy), .delay(delay), .xfer_done(xfer_done));
   // ==========================================
   // Shared tasks
   task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   // Status is read back after every call, before the next one goes out
   task call(input berr_pkg::berr_call_t k, input logic [15:0] n, input logic [2:0] pc,
             input logic [3:0] f, input logic [3:0] code, input logic flag, input logic go);
      int s0;
      s0 = starts;
      @(posedge core_clk) #1;
      call_kind = k;
      call_count = n;
      call_param_count = pc;
      call_flags = f;
      call_valid = 1'b1;
      @(posedge core_clk) #1;
      call_valid = 1'b0;
      check({15'h0000, call_busy}, 16'h0001, "busy");
      for (int i = 0; i < 200 && call_done !== 1'b1; i++) @(posedge core_clk) #1;
      check({15'h0000, call_done}, 16'h0001, "done");
      check({15'h0000, call_busy}, 16'h0000, "idle");
      check({12'h000, bus_error_code}, {12'h000, code}, "code");
      check({15'h0000, error_flag}, {15'h0000, flag}, "flag");
      check({15'h0000, starts != s0}, {15'h0000, go}, "start");
   endtask : call
   // Another controller raises ATN while a slow transfer is pending
   task atn_call(input berr_pkg::berr_call_t k, input logic [3:0] code, input logic flag);
      in_charge = 1'b0;
      delay = 8'h28;
      fork
         call(k, 16'h8, 3'h2, 4'h0, code, flag, 1'b1);
         begin
            repeat (5) @(posedge core_clk);
            #1 atn_in = 1'b1;
         end
      join
      in_charge = 1'b1;
      atn_in = 1'b0;
      delay = 8'h03;
   endtask : atn_call
   // ==========================================
   // Scenarios
   task t_scsi;
      host_mode = berr_pkg::BERR_MODE_SCSI;
      in_charge = 1'b0;
      call(berr_pkg::BERR_CALL_CTRL_FN, 16'h0, 3'h0, 4'h0, 4'h1, 1'b1, 1'b0);
      in_charge = 1'b1;
      call(berr_pkg::BERR_CALL_WRITE, 16'h100, 3'h2, 4'h0, 4'h0, 1'b0, 1'b1);
      call(berr_pkg::BERR_CALL_WRITE, 16'h101, 3'h2, 4'h0, 4'h4, 1'b1, 1'b0);
      listener = 1'b0;
      call(berr_pkg::BERR_CALL_WRITE, 16'h10, 3'h2, 4'h0, 4'h2, 1'b1, 1'b0);
      listener = 1'b1;
      addr = 1'b0;
      call(berr_pkg::BERR_CALL_BREAD, 16'h1, 3'h1, 4'h0, 4'h3, 1'b1, 1'b0);
      call(berr_pkg::BERR_CALL_BWRITE, 16'h1, 3'h1, 4'h0, 4'h3, 1'b1, 1'b0);
      addr = 1'b1;
      call(berr_pkg::BERR_CALL_GTS, 16'h0, 3'h1, 4'h4, 4'h3, 1'b1, 1'b0);
      call(berr_pkg::BERR_CALL_CMD, 16'h2, 3'h1, 4'h0, 4'h0, 1'b0, 1'b1);
      check({15'h0000, atn_out}, 16'h0001, "atn set");
      call(berr_pkg::BERR_CALL_GTS, 16'h0, 3'h1, 4'h4, 4'h0, 1'b0, 1'b1);
      check({15'h0000, atn_out}, 16'h0000, "atn clr");
      atn_call(berr_pkg::BERR_CALL_BWRITE, 4'h2, 1'b1);
      atn_call(berr_pkg::BERR_CALL_DTIN, 4'h0, 1'b0);
      $display("test done: scsi host calls");
   endtask : t_scsi
   task t_gpib;
      host_mode = berr_pkg::BERR_MODE_GPIB;
      call(berr_pkg::BERR_CALL_READ, 16'h8, 3'h2, 4'h2, 4'h4, 1'b1, 1'b0);
      call(berr_pkg::BERR_CALL_READ, 16'h8, 3'h2, 4'h1, 4'h4, 1'b1, 1'b0);
      call(berr_pkg::BERR_CALL_READ, 16'h8, 3'h1, 4'h0, 4'h4, 1'b1, 1'b0);
      call(berr_pkg::BERR_CALL_TID, 16'h0, 3'h0, 4'h0, 4'h4, 1'b1, 1'b0);
      call(berr_pkg::BERR_CALL_TID, 16'h0, 3'h0, 4'h8, 4'h0, 1'b0, 1'b1);
      listener = 1'b0;
      call(berr_pkg::BERR_CALL_WRITE, 16'h8, 3'h2, 4'h0, 4'h2, 1'b1, 1'b0);
      listener = 1'b1;
      atn_call(berr_pkg::BERR_CALL_READ, 4'h2, 1'b1);
      atn_call(berr_pkg::BERR_CALL_DTIN, 4'h2, 1'b1);
      scsi_error = 1'b1;
      call(berr_pkg::BERR_CALL_CTRL_FN, 16'h0, 3'h0, 4'h0, 4'h0, 1'b1, 1'b1);
      check({15'h0000, scsi_side_fault}, 16'h0001, "scsi fault");
      scsi_error = 1'b0;
      call(berr_pkg::BERR_CALL_CTRL_FN, 16'h0, 3'h0, 4'h0, 4'h0, 1'b0, 1'b1);
      check({15'h0000, scsi_side_fault}, 16'h0000, "scsi fault");
      $display("test done: gpib host calls");
   endtask : t_gpib
   initial
   begin
      repeat (2) @(posedge core_clk);
      #1 reset = 1'b0;
      check({12'h000, bus_error_code}, 16'h0000, "reset code");
      check({14'h0000, error_flag, call_busy}, 16'h0000, "reset state");
      t_scsi;
      t_gpib;
      stop_test;
   end
   initial
   begin
      #100000;
      err_total++;
      stop_test;
   end
endmodule : berr_reporter_tb
`default_nettype wire
